// *** shared/lpcs_pkg.sv ***
// Constants and types shared by the transceiver register bank.
package lpcs_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] BASE_BLOCKING = 12'h200;
  localparam logic [11:0] BASE_NONBLOCKING = 12'h300;
  localparam logic [7:0] OFS_CONTROL = 8'h50;
  localparam logic [7:0] OFS_FAULT_STATUS = 8'h52;
  localparam logic [7:0] OFS_LIVE_STATUS = 8'h53;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [7:0] FAULT_RESET = 8'h00;
  localparam int BIT_OVERTEMP_IRQ_ENABLE = 7;
  localparam int BIT_DIRECT = 4;
  localparam int BIT_UVSD = 3;
  localparam int BIT_EN = 2;
  localparam int BIT_SLEW_LO = 0;
  localparam int BIT_OVERTEMP_IRQ_ENABLE_M = 15;
  localparam int BIT_DIRECT_M = 12;
  localparam int BIT_UVSD_M = 11;
  localparam int BIT_EN_M = 10;
  localparam int BIT_SLEW_M_LO = 8;
  localparam int BIT_OT_FLAG = 7;
  localparam int BIT_HF_FLAG = 5;
  localparam int BIT_UV_FLAG = 3;
  localparam int BIT_READY = 7;
  localparam int BIT_RX = 1;
  localparam int BIT_TX = 0;
  localparam int CLOCK_MHZ = 200;
  localparam int READY_DELAY_US = 50;
  localparam int READY_CYCLES = READY_DELAY_US * CLOCK_MHZ;
  typedef enum logic [1:0] {
    SLEW_NORMAL, SLEW_SLOW, SLEW_FAST
  } lpcs_slew_t;
endpackage

// *** src/lpcs_ready_timer.sv ***
// Start-up timer that raises ready a fixed time after enable.
`timescale 1ns/1ps
module lpcs_ready_timer #(
  parameter int CYCLES = lpcs_pkg::READY_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  output logic ready
);
  logic [$clog2(CYCLES+1)-1:0] count_r;

  // Disabling restarts the count so each enable sees the full delay.
  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      count_r <= '0;
      ready <= 1'b0;
    end else if (count_r == ($clog2(CYCLES+1))'(CYCLES - 1)) begin
      ready <= 1'b1;
    end else begin
      count_r <= count_r + 1'b1;
    end
  end
endmodule

// *** src/lpcs_slew_decode.sv ***
// Decoder from the slew select field to the encoded lpcs_slew_t edge-rate mode.
`timescale 1ns/1ps
module lpcs_slew_decode (
  input wire logic [1:0] sel,
  output lpcs_pkg::lpcs_slew_t mode
);
  always_comb begin
    unique case (sel)
      2'h1: mode = lpcs_pkg::SLEW_SLOW;
      2'h2: mode = lpcs_pkg::SLEW_FAST;
      default: mode = lpcs_pkg::SLEW_NORMAL;
    endcase
  end
endmodule

// *** src/lpcs_regs.sv ***
// Control and status register bank of the LIN physical-layer transceiver.
// Behaviour
// [RULE1] Software accesses the control register only as a full 16-bit word.
// [RULE2] Offsets decode relative to base 0x200 and to base 0x300.
// [RULE3] Interrupt enable bit 7 changes only when mask bit 15 is written.
// [RULE4] Direct drive bit 4 changes only when mask bit 12 is written.
// [RULE5] Undervoltage shutdown disable bit 3 changes only with mask bit 11.
// [RULE6] Module enable bit 2 changes only when mask bit 10 is written.
// [RULE7] Slew select changes only when mask bits 9-8 are written as 11.
// [RULE8] Overtemperature raises an interrupt only while the enable is 1.
// [RULE9] Direct drive at 1 forces the bus dominant; at 0 no effect.
// [RULE10] Without shutdown disable, undervoltage holds the bus recessive.
// [RULE11] The transceiver runs only while the module enable bit is 1.
// [RULE12] Slew 00/11 normal, 01 slow, 10 fast edges.
// [RULE13] Overtemperature latches fault bit 7, cleared by writing 1.
// [RULE14] HF disturbance latches fault bit 5, cleared by writing 1.
// [RULE15] Undervoltage latches fault bit 3, cleared by writing 1.
// [RULE16] Live status bit 7 shows transmitter readiness.
// [RULE17] Live bits 1 and 0 show receiver and transmitter levels.
// [RULE18] Mask and unused bits read zero; writes to unused bits ignored.
// [RULE19] Ready rises about 50 us after enable; bus recessive until then.
// [RULE20] Overtemperature shuts the driver off until gone and input high.
// [RULE21] A new interrupt needs overtemperature to clear and then recur.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module lpcs_regs #(
  parameter int READY_CYCLES = lpcs_pkg::READY_CYCLES
) (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port.
  input wire logic [lpcs_pkg::ADDR_W-1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Transmit data from the routed source, high means recessive.
  input wire logic TXD_IN,
  // Analog condition inputs.
  input wire logic OVERTEMP,
  input wire logic HF_DISTURB,
  input wire logic UNDERVOLT,
  input wire logic BUS_RX,
  // Transceiver controls.
  output logic BUS_DOMINANT,
  output logic MODULE_ON,
  output logic [1:0] SLEW_MODE,
  output logic OVERTEMP_IRQ
);
  logic overtemp_irq_enable_r;
  logic direct_drive_r;
  logic undervolt_shutdown_disable_r;
  logic module_enable_r;
  logic [1:0] slew_select_r;
  logic overtemp_flag_r;
  logic hf_disturb_flag_r;
  logic undervolt_flag_r;
  logic ot_prev_r;
  logic tx_blocked_r;
  logic ready;
  logic hit;
  logic [7:0] ofs;
  logic wr_ctl;
  logic wr_flt;
  logic ot_rise;
  logic tx_dom_nxt;
  logic [7:0] fault_byte;
  logic [7:0] live_byte;
  lpcs_pkg::lpcs_slew_t slew_mode;

  // Register select inside either window, shared by the write decoders.
  function automatic logic reg_sel(
    input logic [lpcs_pkg::ADDR_W-1:0] addr,
    input logic [7:0] offset
  );
    logic in_window;
    in_window = (addr[11:8] == lpcs_pkg::BASE_BLOCKING[11:8]) ||
      (addr[11:8] == lpcs_pkg::BASE_NONBLOCKING[11:8]);
    return in_window && (addr[7:0] == offset);
  endfunction

  // Writing one clears a fault bit; the caller lets a new event win.
  function automatic logic w1c(
    input logic wr_en,
    input logic [15:0] data,
    input int pos
  );
    return wr_en && data[pos];
  endfunction

  // Both windows map the same registers; the top nibble picks the window.
  always_comb begin
    hit = (ADDR[11:8] == lpcs_pkg::BASE_BLOCKING[11:8]) ||
          (ADDR[11:8] == lpcs_pkg::BASE_NONBLOCKING[11:8]); // [RULE2]
    ofs = ADDR[7:0];
  end

  // Control writes are taken as whole words only, so no byte lanes exist.
  assign wr_ctl = WR && reg_sel(ADDR, lpcs_pkg::OFS_CONTROL); // [RULE1]
  assign wr_flt = WR && reg_sel(ADDR, lpcs_pkg::OFS_FAULT_STATUS);
  assign ot_rise = OVERTEMP && !ot_prev_r;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      overtemp_irq_enable_r <= lpcs_pkg::CONTROL_RESET[lpcs_pkg::BIT_OVERTEMP_IRQ_ENABLE];
    end else if (wr_ctl && WDATA[lpcs_pkg::BIT_OVERTEMP_IRQ_ENABLE_M]) begin
      overtemp_irq_enable_r <= WDATA[lpcs_pkg::BIT_OVERTEMP_IRQ_ENABLE]; // [RULE3]
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      direct_drive_r <= lpcs_pkg::CONTROL_RESET[lpcs_pkg::BIT_DIRECT];
    end else if (wr_ctl && WDATA[lpcs_pkg::BIT_DIRECT_M]) begin
      direct_drive_r <= WDATA[lpcs_pkg::BIT_DIRECT]; // [RULE4]
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      undervolt_shutdown_disable_r <=
        lpcs_pkg::CONTROL_RESET[lpcs_pkg::BIT_UVSD];
    end else if (wr_ctl && WDATA[lpcs_pkg::BIT_UVSD_M]) begin
      undervolt_shutdown_disable_r <= WDATA[lpcs_pkg::BIT_UVSD]; // [RULE5]
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      module_enable_r <= lpcs_pkg::CONTROL_RESET[lpcs_pkg::BIT_EN];
    end else if (wr_ctl && WDATA[lpcs_pkg::BIT_EN_M]) begin
      module_enable_r <= WDATA[lpcs_pkg::BIT_EN]; // [RULE6]
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      slew_select_r <= lpcs_pkg::CONTROL_RESET[1:0];
    end else if (wr_ctl &&
                 (&WDATA[lpcs_pkg::BIT_SLEW_M_LO +: 2])) begin
      slew_select_r <= WDATA[lpcs_pkg::BIT_SLEW_LO +: 2]; // [RULE7]
    end
  end

  // Set wins over a clear written in the same cycle, so no event is lost.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      overtemp_flag_r <= lpcs_pkg::FAULT_RESET[lpcs_pkg::BIT_OT_FLAG];
    end else if (OVERTEMP) begin
      overtemp_flag_r <= 1'b1; // [RULE13]
    end else if (w1c(wr_flt, WDATA, lpcs_pkg::BIT_OT_FLAG)) begin
      overtemp_flag_r <= 1'b0; // [RULE13]
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      hf_disturb_flag_r <= lpcs_pkg::FAULT_RESET[lpcs_pkg::BIT_HF_FLAG];
    end else if (HF_DISTURB) begin
      hf_disturb_flag_r <= 1'b1; // [RULE14]
    end else if (w1c(wr_flt, WDATA, lpcs_pkg::BIT_HF_FLAG)) begin
      hf_disturb_flag_r <= 1'b0; // [RULE14]
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      undervolt_flag_r <= lpcs_pkg::FAULT_RESET[lpcs_pkg::BIT_UV_FLAG];
    end else if (UNDERVOLT) begin
      undervolt_flag_r <= 1'b1; // [RULE15]
    end else if (w1c(wr_flt, WDATA, lpcs_pkg::BIT_UV_FLAG)) begin
      undervolt_flag_r <= 1'b0; // [RULE15]
    end
  end

  // Interrupt request pulses once per rising overtemperature event while the interrupt enable is 1.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ot_prev_r <= 1'b0;
      OVERTEMP_IRQ <= 1'b0;
    end else begin
      ot_prev_r <= OVERTEMP;
      OVERTEMP_IRQ <= ot_rise && overtemp_irq_enable_r; // [RULE8] [RULE21]
    end
  end

  // After overtemperature the driver stays off until the input idles high.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      tx_blocked_r <= 1'b0;
    end else if (OVERTEMP) begin
      tx_blocked_r <= 1'b1; // [RULE20]
    end else if (TXD_IN) begin
      tx_blocked_r <= 1'b0; // [RULE20]
    end
  end

  lpcs_ready_timer #(
    .CYCLES(READY_CYCLES)
  ) u_ready (
    .clk(CLOCK),
    .rst_n(RST_N),
    .enable(module_enable_r),
    .ready(ready)
  ); // [RULE19]

  lpcs_slew_decode u_slew (
    .sel(slew_select_r),
    .mode(slew_mode)
  ); // [RULE12]

  // Status bytes are built apart so each read case stays a single line.
  always_comb begin
    fault_byte = 8'h00; // [RULE18]
    fault_byte[lpcs_pkg::BIT_OT_FLAG] = overtemp_flag_r;
    fault_byte[lpcs_pkg::BIT_HF_FLAG] = hf_disturb_flag_r;
    fault_byte[lpcs_pkg::BIT_UV_FLAG] = undervolt_flag_r;
  end

  always_comb begin
    live_byte = 8'h00; // [RULE18]
    live_byte[lpcs_pkg::BIT_READY] = ready; // [RULE16]
    live_byte[lpcs_pkg::BIT_RX] = BUS_RX; // [RULE17]
    live_byte[lpcs_pkg::BIT_TX] = BUS_DOMINANT; // [RULE17]
  end

  always_comb begin
    tx_dom_nxt = direct_drive_r || !TXD_IN; // [RULE9]
    if (!module_enable_r || !ready || OVERTEMP || tx_blocked_r) begin
      tx_dom_nxt = 1'b0; // [RULE11] [RULE19] [RULE20]
    end
    if (UNDERVOLT && !undervolt_shutdown_disable_r) begin
      tx_dom_nxt = 1'b0; // [RULE10]
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      BUS_DOMINANT <= 1'b0;
      MODULE_ON <= 1'b0;
      SLEW_MODE <= 2'h0;
    end else begin
      BUS_DOMINANT <= tx_dom_nxt;
      MODULE_ON <= module_enable_r; // [RULE11]
      SLEW_MODE <= slew_mode; // [RULE12]
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge CLOCK) begin
    if (!RST_N || !RD || !hit) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= 16'h0000; // [RULE18]
      unique case (ofs)
        lpcs_pkg::OFS_CONTROL: begin
          RDATA[lpcs_pkg::BIT_OVERTEMP_IRQ_ENABLE] <= overtemp_irq_enable_r;
          RDATA[lpcs_pkg::BIT_DIRECT] <= direct_drive_r;
          RDATA[lpcs_pkg::BIT_UVSD] <= undervolt_shutdown_disable_r;
          RDATA[lpcs_pkg::BIT_EN] <= module_enable_r;
          RDATA[1:0] <= slew_select_r;
        end
        lpcs_pkg::OFS_FAULT_STATUS: begin
          RDATA[7:0] <= fault_byte; // [RULE13] [RULE14] [RULE15]
        end
        lpcs_pkg::OFS_LIVE_STATUS: begin
          RDATA[7:0] <= live_byte; // [RULE16] [RULE17]
        end
        default: RDATA <= 16'h0000;
      endcase
    end
  end
endmodule

// *** sim/lpcs_properties.sv ***
// Port checker for the transceiver register bank.
`timescale 1ns/1ps
module lpcs_properties #(
  parameter int READY_CYCLES = lpcs_pkg::READY_CYCLES
) (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port.
  input wire logic [lpcs_pkg::ADDR_W-1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // Conditions and controls.
  input wire logic TXD_IN,
  input wire logic OVERTEMP,
  input wire logic HF_DISTURB,
  input wire logic UNDERVOLT,
  input wire logic BUS_RX,
  input wire logic BUS_DOMINANT,
  input wire logic MODULE_ON,
  input wire logic [1:0] SLEW_MODE,
  input wire logic OVERTEMP_IRQ
);
  logic win;
  logic ctl_wr;
  logic live_rd;
  assign win = (ADDR[11:8] == 4'h2) || (ADDR[11:8] == 4'h3);
  assign ctl_wr = WR && win && (ADDR[7:0] == lpcs_pkg::OFS_CONTROL);
  assign live_rd = RD && win && (ADDR[7:0] == lpcs_pkg::OFS_LIVE_STATUS);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  property p_rdata_idle;
    !$past(RD) |-> RDATA == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read cycle");
  property p_on_set;
    ctl_wr && WDATA[10] && WDATA[2] |-> ##2 MODULE_ON;
  endproperty
  a_on_set: assert property (p_on_set)
    else $error("enable write did not switch module on");
  property p_on_clr;
    ctl_wr && WDATA[10] && !WDATA[2] |-> ##2 !MODULE_ON;
  endproperty
  a_on_clr: assert property (p_on_clr)
    else $error("disable write did not switch module off");
  property p_on_keep;
    ctl_wr && !WDATA[10] |-> ##2 $stable(MODULE_ON);
  endproperty
  a_on_keep: assert property (p_on_keep)
    else $error("enable changed without its mask");
  property p_slew_fast;
    ctl_wr && WDATA[9:8] == 2'h3 && WDATA[1:0] == 2'h2 |->
      ##[1:2] SLEW_MODE == 2'h2;
  endproperty
  a_slew_fast: assert property (p_slew_fast)
    else $error("fast slew not selected");
  property p_dom_hold;
    $rose(MODULE_ON) |-> !BUS_DOMINANT [*6];
  endproperty
  a_dom_hold: assert property (p_dom_hold)
    else $error("bus driven before ready");
  property p_ot_off;
    OVERTEMP [*3] |=> !BUS_DOMINANT;
  endproperty
  a_ot_off: assert property (p_ot_off)
    else $error("bus driven during overtemperature");
  property p_irq_cause;
    OVERTEMP_IRQ |-> $past(OVERTEMP) || $past(OVERTEMP, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without overtemperature");
  property p_irq_once;
    OVERTEMP_IRQ |=> !OVERTEMP_IRQ;
  endproperty
  a_irq_once: assert property (p_irq_once)
    else $error("interrupt longer than one cycle");
  property p_live;
    live_rd |=> RDATA[15:8] == 8'h00 && RDATA[6:2] == 5'h00 &&
      RDATA[1] == $past(BUS_RX) && RDATA[0] == $past(BUS_DOMINANT);
  endproperty
  a_live: assert property (p_live)
    else $error("live status does not match bus levels");
endmodule

bind lpcs_regs lpcs_properties #(.READY_CYCLES(READY_CYCLES)) u_props (
  .CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .TXD_IN(TXD_IN), .OVERTEMP(OVERTEMP),
  .HF_DISTURB(HF_DISTURB), .UNDERVOLT(UNDERVOLT), .BUS_RX(BUS_RX),
  .BUS_DOMINANT(BUS_DOMINANT), .MODULE_ON(MODULE_ON),
  .SLEW_MODE(SLEW_MODE), .OVERTEMP_IRQ(OVERTEMP_IRQ)
);

// *** sim/lpcs_bus_model.sv ***
// Single-wire bus line shared by this node and remote nodes.
`timescale 1ns/1ps
module lpcs_bus_model (
  // Drivers, high pulls the line dominant.
  input wire logic dut_dom,
  input wire logic remote_dom,
  // Receiver level.
  output logic bus_rx
);
  // The pull-up wins unless any node pulls down, so dominant is an OR.
  assign bus_rx = dut_dom | remote_dom;
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the transceiver register bank.
`timescale 1ns/1ps
module tb_top;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic [11:0] ADDR = 12'h000;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic TXD_IN = 1'b1;
  logic OVERTEMP = 1'b0;
  logic HF_DISTURB = 1'b0;
  logic UNDERVOLT = 1'b0;
  logic remote_dom = 1'b0;
  logic BUS_RX;
  logic [15:0] RDATA;
  logic BUS_DOMINANT;
  logic MODULE_ON;
  logic [1:0] SLEW_MODE;
  logic OVERTEMP_IRQ;
  logic rd_seen = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] acc;
  int num_errors = 0;
  int tests_run = 0;
  int irq_cnt = 0;
  localparam logic [15:0] MSK[8] = '{16'h0000, 16'h0100, 16'h0200,
    16'h8000, 16'h1000, 16'h0800, 16'h0400, 16'h0300};
  localparam logic [15:0] FLD[8] = '{16'h0000, 16'h0000, 16'h0000,
    16'h0080, 16'h0010, 16'h0008, 16'h0004, 16'h0003};
  localparam logic [1:0] SLW[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  lpcs_regs #(.READY_CYCLES(8)) dut (.CLOCK(CLOCK), .RST_N(RST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .TXD_IN(TXD_IN), .OVERTEMP(OVERTEMP), .HF_DISTURB(HF_DISTURB),
    .UNDERVOLT(UNDERVOLT), .BUS_RX(BUS_RX), .BUS_DOMINANT(BUS_DOMINANT),
    .MODULE_ON(MODULE_ON), .SLEW_MODE(SLEW_MODE),
    .OVERTEMP_IRQ(OVERTEMP_IRQ));
  lpcs_bus_model u_bus (.dut_dom(BUS_DOMINANT), .remote_dom(remote_dom),
    .bus_rx(BUS_RX));
  always #2.5 CLOCK = ~CLOCK;
  task automatic check(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Every write leaves one idle cycle so a strobe is never set twice.
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    exp_q.push_back(e);
    @(posedge CLOCK);
    RD <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic dom(input logic e);
    check("dominant", {15'h0000, BUS_DOMINANT}, {15'h0000, e});
  endtask
  always @(posedge CLOCK) begin
    rd_seen <= RD;
    if (rd_seen) check("rdata", RDATA, exp_q.pop_front());
    if (OVERTEMP_IRQ === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(45));
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    rd(12'h250, 16'h0000);
    rd(12'h252, 16'h0000);
    rd(12'h253, 16'h0000);
    rd(12'h254, 16'h0000);
    rd(12'h150, 16'h0000);
    $display("test reset done");
    acc = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      wr(i[0] ? 12'h350 : 12'h250, MSK[i] | 16'h60FF);
      acc = acc | FLD[i];
      rd(12'h250, acc);
    end
    repeat (4) begin
      wr(12'h250, 16'($urandom()) & 16'h60FF);
      rd(12'h350, acc);
    end
    for (int c = 0; c < 4; c++) begin
      wr(12'h250, 16'h0300 | 16'(c));
      wt(2);
      check("slew", {14'h0000, SLEW_MODE}, {14'h0000, SLW[c]});
    end
    wr(12'h250, 16'h9F00);
    wt(2);
    check("on", {15'h0000, MODULE_ON}, 16'h0000);
    $display("test masks done");
    @(posedge CLOCK) remote_dom <= 1'b1;
    rd(12'h253, 16'h0002);
    remote_dom <= 1'b0;
    wr(12'h250, 16'h1414);
    wt(1);
    check("on", {15'h0000, MODULE_ON}, 16'h0001);
    rd(12'h253, 16'h0000);
    wt(12);
    dom(1'b1);
    rd(12'h253, 16'h0083);
    wr(12'h250, 16'h1000);
    wt(2);
    dom(1'b0);
    @(posedge CLOCK) TXD_IN <= 1'b0;
    wt(2);
    dom(1'b1);
    @(posedge CLOCK) TXD_IN <= 1'b1;
    $display("test ready done");
    wr(12'h250, 16'h1010);
    @(posedge CLOCK) UNDERVOLT <= 1'b1;
    wt(3);
    dom(1'b0);
    rd(12'h252, 16'h0008);
    wr(12'h250, 16'h0808);
    wt(3);
    dom(1'b1);
    @(posedge CLOCK) UNDERVOLT <= 1'b0;
    wr(12'h252, 16'h0008);
    rd(12'h252, 16'h0000);
    $display("test undervoltage done");
    @(posedge CLOCK) OVERTEMP <= 1'b1;
    wt(3);
    dom(1'b0);
    @(posedge CLOCK) OVERTEMP <= 1'b0;
    wt(3);
    dom(1'b1);
    check("irq", 16'(irq_cnt), 16'h0000);
    rd(12'h252, 16'h0080);
    wr(12'h252, 16'h0080);
    rd(12'h252, 16'h0000);
    wr(12'h250, 16'h8080);
    repeat (2) begin
      @(posedge CLOCK) OVERTEMP <= 1'b1;
      wt(4);
      @(posedge CLOCK) OVERTEMP <= 1'b0;
      wt(2);
    end
    check("irq", 16'(irq_cnt), 16'h0002);
    $display("test overtemperature done");
    @(posedge CLOCK) HF_DISTURB <= 1'b1;
    @(posedge CLOCK) HF_DISTURB <= 1'b0;
    wr(12'h252, 16'h00DF);
    rd(12'h252, 16'h0020);
    wr(12'h252, 16'h0020);
    rd(12'h252, 16'h0000);
    wt(3);
    $display("test disturbance done");
    stop_test();
  end
endmodule
